// ---- shared/mbx_map.svh ----
// Address, port, field, vector and reset constants of the host mailbox
`ifndef MBX_MAP_SVH
`define MBX_MAP_SVH

// Host I/O map: bits 7..1 must read 1000000
`define MBX_HOST_UPPER 7'h40
`define MBX_HOST_DATA_ADDR 8'h80
`define MBX_HOST_CTRL_ADDR 8'h81

// Local CPU I/O ports
`define MBX_PORT_OUT_WR 8'h00
`define MBX_PORT_RESET_WR 8'h01
`define MBX_PORT_IN_RD 8'h03

// Vectors handed out on acknowledge
`define MBX_VEC_FETCH 8'h02
`define MBX_VEC_CMD 8'h04
`define MBX_VEC_STORE 8'h08
`define MBX_VEC_NONE 8'h00

// Status byte fields
`define MBX_ST_OUT_FULL 0
`define MBX_ST_IN_BUSY 1
`define MBX_ST_FETCH_PEND 2
`define MBX_ST_CMD_PEND 3
`define MBX_ST_ID_LSB 4

// Reset values
`define MBX_BYTE_RST 8'h00
`define MBX_ID_RST 4'hA

`endif

// ---- shared/mbx_pkg.sv ----
// Types shared by the host mailbox design files
package mbx_pkg;

  // Host I/O bus as seen at the unit's pins
  typedef struct packed {
    logic [7:0] addr;
    logic io_request_strobe_n;
    logic rd_n;
    logic wr_n;
    logic [7:0] data;
  } mbx_host_bus_type;

  // Decoded host strobes
  typedef struct packed {
    logic status_fetch;
    logic cmd_write;
    logic byte_fetch;
    logic byte_store;
  } mbx_strobe_type;

  // One byte travelling from host to unit
  typedef struct packed {
    logic is_cmd;
    logic [7:0] data;
  } mbx_entry_type;

endpackage : mbx_pkg

// ---- hw/mbx_decode.sv ----
// Host address and command decoder producing levels and first-cycle pulses
`timescale 1ns/1ns
`include "mbx_map.svh"

module mbx_decode (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Host bus
  input wire mbx_pkg::mbx_host_bus_type host_bus,
  // Decoded strobes
  output mbx_pkg::mbx_strobe_type level,
  output mbx_pkg::mbx_strobe_type pulse
);

  mbx_pkg::mbx_strobe_type prev_reg;
  mbx_pkg::mbx_strobe_type prev_next;
  logic selected;
  logic low_addr_select;

  always_comb begin
    selected = (host_bus.addr[7:1] == `MBX_HOST_UPPER) &&
               !host_bus.io_request_strobe_n;
    low_addr_select = host_bus.addr[0];
    level.status_fetch = selected && low_addr_select && !host_bus.rd_n;
    level.cmd_write = selected && low_addr_select && !host_bus.wr_n;
    level.byte_fetch = selected && !low_addr_select && !host_bus.rd_n;
    level.byte_store = selected && !low_addr_select && !host_bus.wr_n;
    pulse = level & ~prev_reg;
    prev_next = level;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      prev_reg <= '0;
    end else begin
      prev_reg <= prev_next;
    end
  end

endmodule : mbx_decode

// ---- hw/mbx_fifo2.sv ----
// Small valid/ready buffer between host byte writes and the input register
`timescale 1ns/1ns

module mbx_fifo2 #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
  logic [AW:0] cnt_reg, cnt_next;
  logic push, pop;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : bump

  always_comb begin
    in_ready = (cnt_reg != (AW+1)'(DEPTH));
    out_valid = (cnt_reg != '0);
    out_data = mem_reg[rd_reg];
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    wr_next = push ? bump(wr_reg) : wr_reg;
    rd_next = pop ? bump(rd_reg) : rd_reg;
    cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
    end
  end

  // Storage needs no reset; it is read only behind a count
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data;
    end
  end

endmodule : mbx_fifo2

// ---- hw/mbx_mailbox.sv ----
// Host-to-unit mailbox: decoder, pending flags, holding registers, vectors
`timescale 1ns/1ns
`include "mbx_map.svh"

// Behaviour
// - Answer host I/O only at 80h and 81h with the request strobe low.
// - Host address bit 0 picks between the two decoded selects.
// - Host read at 81h is the status fetch returning the status byte.
// - Host write at 81h is the command write into the unit.
// - Host read at 80h is the byte fetch from the unit.
// - Host write at 80h is the byte store into the unit.
// - Status fetch is answered on the cycle after the select, without the local CPU.
// - Every other strobe sets its own sticky pending flag until cleared.
// - Local read of port 03h clears the consumed request flags.
// - Host reset or local write of port 01h clears all pending flags.
// - Two separate 8-bit holding registers, one per direction.
// - Each holding register captures its source bus on its latch strobe; the input register loads from the buffer head instead.
// - Holding registers drive their bus only while enabled, else float.
// - Input register holds host bytes, read by local CPU at port 03h.
// - Output register loads on local port 00h write, host reads at 80h.
// - Direction high passes unit to host, low passes host to unit.
// - Acknowledge returns vector 02h fetch, 04h command, 08h store.
// - The serviced flag clears when the acknowledge ends, on vector_acknowledge_n rising.
// - Status shows whether the output register holds an unfetched byte.
module mbx_mailbox #(
  parameter logic [3:0] UNIT_ID = `MBX_ID_RST, // Arbitrary value
  parameter int BUF_DEPTH = 2
) (
  // Clock and reset (reset is the host system reset)
  input wire logic core_clk,
  input wire logic sys_rst,
  // Host I/O bus
  input wire mbx_pkg::mbx_host_bus_type host_bus,
  output logic [7:0] host_data_out,
  output logic host_data_oe,
  output logic host_dir,
  output logic host_ready,
  // Local CPU I/O bus
  input wire logic [7:0] local_port,
  input wire logic local_io_request_strobe_n,
  input wire logic local_rd_n,
  input wire logic local_wr_n,
  input wire logic vector_acknowledge_n,
  input wire logic [7:0] local_data_in,
  output logic [7:0] local_data_out,
  output logic local_data_oe,
  output logic local_irq_n
);

  mbx_pkg::mbx_strobe_type lvl, pls;
  mbx_pkg::mbx_entry_type fifo_in, fifo_out;
  logic fifo_in_ready, fifo_out_valid, fifo_pop;

  // Pending flags and holding registers
  logic pend_fetch_reg, pend_fetch_next;
  logic pend_cmd_reg, pend_cmd_next;
  logic pend_store_reg, pend_store_next;
  logic [7:0] out_reg, out_next;
  logic out_full_reg, out_full_next;
  logic [7:0] in_reg, in_next;
  logic in_full_reg, in_full_next;
  logic in_cmd_reg, in_cmd_next;
  // Local bus edge history
  logic in_rd_reg, in_rd_next;
  logic ack_reg, ack_next;
  // Registered pin drivers
  logic [7:0] host_data_reg, host_data_next;
  logic host_oe_reg, host_oe_next;
  logic host_dir_reg, host_dir_next;
  logic host_ready_reg, host_ready_next;
  logic [7:0] loc_data_reg, loc_data_next;
  logic loc_oe_reg, loc_oe_next;
  logic irq_n_reg, irq_n_next;

  // Local decode
  logic loc_in_rd, loc_out_wr, loc_prg_rst, in_rd_end, ack_on, ack_end;
  logic [7:0] status_byte, vector_byte;

  mbx_decode u_decode (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .host_bus(host_bus),
    .level(lvl),
    .pulse(pls)
  );

  // Host writes queue here so a slow local CPU loses no byte
  always_comb begin
    fifo_in.is_cmd = pls.cmd_write;
    fifo_in.data = host_bus.data;
  end

  mbx_fifo2 #(
    .WIDTH($bits(mbx_pkg::mbx_entry_type)),
    .DEPTH(BUF_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .in_valid(pls.cmd_write || pls.byte_store),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in),
    .out_valid(fifo_out_valid),
    .out_ready(!in_full_reg),
    .out_data(fifo_out)
  );

  function automatic logic loc_hit(input logic [7:0] port,
                                   input logic [7:0] want,
                                   input logic strobe_n);
    loc_hit = !local_io_request_strobe_n && !strobe_n && (port == want);
  endfunction : loc_hit

  always_comb begin
    loc_in_rd = loc_hit(local_port, `MBX_PORT_IN_RD, local_rd_n);
    loc_out_wr = loc_hit(local_port, `MBX_PORT_OUT_WR, local_wr_n);
    loc_prg_rst = loc_hit(local_port, `MBX_PORT_RESET_WR, local_wr_n);
    in_rd_end = in_rd_reg && !loc_in_rd;
    ack_on = !vector_acknowledge_n;
    ack_end = ack_reg && !ack_on;
    fifo_pop = fifo_out_valid && !in_full_reg;
    status_byte = {UNIT_ID, pend_cmd_reg, pend_fetch_reg,
                   in_full_reg || fifo_out_valid, out_full_reg};
    // Fetch first, then command, then store
    if (pend_fetch_reg) begin
      vector_byte = `MBX_VEC_FETCH;
    end else if (pend_cmd_reg) begin
      vector_byte = `MBX_VEC_CMD;
    end else if (pend_store_reg) begin
      vector_byte = `MBX_VEC_STORE;
    end else begin
      vector_byte = `MBX_VEC_NONE;
    end
  end

  always_comb begin
    // Set beats a clear arriving in the same cycle
    pend_fetch_next = pend_fetch_reg;
    pend_cmd_next = pend_cmd_reg;
    pend_store_next = pend_store_reg;
    if (ack_end && vector_byte == `MBX_VEC_FETCH) begin
      pend_fetch_next = 1'b0;
    end
    if ((ack_end && vector_byte == `MBX_VEC_CMD) || in_rd_end) begin
      pend_cmd_next = 1'b0;
    end
    if ((ack_end && vector_byte == `MBX_VEC_STORE) || in_rd_end) begin
      pend_store_next = 1'b0;
    end
    if (loc_prg_rst) begin
      pend_fetch_next = 1'b0;
      pend_cmd_next = 1'b0;
      pend_store_next = 1'b0;
    end
    pend_fetch_next = pend_fetch_next || pls.byte_fetch;
    pend_cmd_next = pend_cmd_next || pls.cmd_write;
    pend_store_next = pend_store_next || pls.byte_store;

    // Output register: local writes port 00h, host fetch empties it
    out_next = loc_out_wr ? local_data_in : out_reg;
    out_full_next = loc_out_wr || (out_full_reg && !pls.byte_fetch);

    // Input register loads from the buffer head once it is empty
    in_next = fifo_pop ? fifo_out.data : in_reg;
    in_cmd_next = fifo_pop ? fifo_out.is_cmd : in_cmd_reg;
    in_full_next = fifo_pop || (in_full_reg && !in_rd_end);

    in_rd_next = loc_in_rd;
    ack_next = ack_on;

    // Host side drive, one cycle after the select
    host_oe_next = lvl.status_fetch || lvl.byte_fetch;
    host_dir_next = host_oe_next;
    host_data_next = lvl.status_fetch ? status_byte : out_reg;
    host_ready_next = fifo_in_ready;

    // Local side drive: vector wins over a port read
    loc_oe_next = ack_on || loc_in_rd;
    loc_data_next = ack_on ? vector_byte : in_reg;
    irq_n_next = !(pend_fetch_next || pend_cmd_next || pend_store_next);
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pend_fetch_reg <= 1'b0;
      pend_cmd_reg <= 1'b0;
      pend_store_reg <= 1'b0;
      out_reg <= `MBX_BYTE_RST;
      out_full_reg <= 1'b0;
      in_reg <= `MBX_BYTE_RST;
      in_cmd_reg <= 1'b0;
      in_full_reg <= 1'b0;
      in_rd_reg <= 1'b0;
      ack_reg <= 1'b0;
      host_data_reg <= `MBX_BYTE_RST;
      host_oe_reg <= 1'b0;
      host_dir_reg <= 1'b0;
      host_ready_reg <= 1'b0;
      loc_data_reg <= `MBX_BYTE_RST;
      loc_oe_reg <= 1'b0;
      irq_n_reg <= 1'b1;
    end else begin
      pend_fetch_reg <= pend_fetch_next;
      pend_cmd_reg <= pend_cmd_next;
      pend_store_reg <= pend_store_next;
      out_reg <= out_next;
      out_full_reg <= out_full_next;
      in_reg <= in_next;
      in_cmd_reg <= in_cmd_next;
      in_full_reg <= in_full_next;
      in_rd_reg <= in_rd_next;
      ack_reg <= ack_next;
      host_data_reg <= host_data_next;
      host_oe_reg <= host_oe_next;
      host_dir_reg <= host_dir_next;
      host_ready_reg <= host_ready_next;
      loc_data_reg <= loc_data_next;
      loc_oe_reg <= loc_oe_next;
      irq_n_reg <= irq_n_next;
    end
  end

  assign host_data_out = host_data_reg;
  assign host_data_oe = host_oe_reg;
  assign host_dir = host_dir_reg;
  assign host_ready = host_ready_reg;
  assign local_data_out = loc_data_reg;
  assign local_data_oe = loc_oe_reg;
  assign local_irq_n = irq_n_reg;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  host_window_a: assert property (
    (pls != '0) |-> (host_bus.addr[7:1] == `MBX_HOST_UPPER &&
                     !host_bus.io_request_strobe_n))
    else $error("strobe outside the host window");

  addr_bit_a: assert property (
    (pls.cmd_write || pls.status_fetch) |-> host_bus.addr[0])
    else $error("control select without address bit 0");

  status_drive_a: assert property (
    lvl.status_fetch |=> host_data_oe && host_dir &&
      host_data_out == {UNIT_ID, $past(pend_cmd_reg),
                        $past(pend_fetch_reg),
                        $past(in_full_reg || fifo_out_valid),
                        $past(out_full_reg)})
    else $error("status byte not driven next cycle");

  fetch_data_a: assert property (
    (lvl.byte_fetch && !lvl.status_fetch) |=>
      host_data_oe && host_data_out == $past(out_reg))
    else $error("host fetch does not return output register");

  cmd_sticky_a: assert property (
    pls.cmd_write |=> pend_cmd_reg && !local_irq_n)
    else $error("command flag or interrupt not raised");

  store_sticky_a: assert property (
    (pend_store_reg && !in_rd_end && !loc_prg_rst && !ack_end)
      |=> pend_store_reg)
    else $error("store flag dropped without a clear");

  prog_reset_a: assert property (
    (loc_prg_rst && pls == '0) |=>
      !pend_fetch_reg && !pend_cmd_reg && !pend_store_reg)
    else $error("program reset left a flag set");

  port_clear_a: assert property (
    (in_rd_end && !pls.cmd_write && !pls.byte_store) |=>
      !pend_cmd_reg && !pend_store_reg)
    else $error("port read left a request flag set");

  vector_fetch_a: assert property (
    (ack_on && pend_fetch_reg) |=>
      local_data_oe && local_data_out == `MBX_VEC_FETCH)
    else $error("wrong vector for byte fetch");

  ack_clear_a: assert property (
    (ack_end && vector_byte == `MBX_VEC_FETCH && !pls.byte_fetch)
      |=> !pend_fetch_reg)
    else $error("fetch flag not cleared on acknowledge end");

  out_full_a: assert property (
    loc_out_wr |=> out_full_reg ##1 (status_byte[`MBX_ST_OUT_FULL] ||
                                     $past(pls.byte_fetch)))
    else $error("output full not shown in status");

  hold_float_a: assert property (
    (!lvl.status_fetch && !lvl.byte_fetch) |=> !host_data_oe)
    else $error("host bus driven without a read");

  cmd_cov: cover property (pls.cmd_write ##[1:20] in_rd_end);
  fetch_cov: cover property (loc_out_wr ##[1:20] pls.byte_fetch);
  full_cov: cover property (!host_ready ##1 in_rd_end);
  cmd_byte_cov: cover property (in_cmd_reg && loc_in_rd);
  prg_cov: cover property (loc_prg_rst && pend_store_reg);

endmodule : mbx_mailbox

// ---- tb/mbx_host_model.sv ----
// Behavioural host CPU on the unit's I/O bus
`timescale 1ns/1ns

module mbx_host_model (
  // Clock
  input wire logic core_clk,
  // Unit side
  output mbx_pkg::mbx_host_bus_type host_bus,
  input wire logic [7:0] host_data_out,
  input wire logic host_data_oe,
  input wire logic host_dir,
  input wire logic host_ready,
  // Set once a write gave up waiting for the unit
  output logic wait_expired
);
  logic expired_reg = 1'b0;
  logic [7:0] addr_reg = 8'h00;
  logic strb_n_reg = 1'b1;
  logic rd_n_reg = 1'b1;
  logic wr_n_reg = 1'b1;
  logic [7:0] wdat_reg = 8'h00;

  assign wait_expired = expired_reg;

  // A released bus shows the inverse of the last byte, never a stale copy
  always_comb begin
    host_bus.addr = addr_reg;
    host_bus.io_request_strobe_n = strb_n_reg;
    host_bus.rd_n = rd_n_reg;
    host_bus.wr_n = wr_n_reg;
    if (!wr_n_reg) host_bus.data = wdat_reg;
    else if (host_data_oe) host_bus.data = host_data_out;
    else host_bus.data = ~wdat_reg;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int n = 0;
    while (host_ready !== 1'b1 && n < 50) begin
      @(posedge core_clk);
      n++;
    end
    if (n == 50) begin
      expired_reg <= 1'b1;
    end
    @(posedge core_clk);
    addr_reg <= a;
    wdat_reg <= d;
    strb_n_reg <= 1'b0;
    wr_n_reg <= 1'b0;
    @(posedge core_clk);
    strb_n_reg <= 1'b1;
    wr_n_reg <= 1'b1;
    repeat (2) @(posedge core_clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output logic oe, output logic dir);
    @(posedge core_clk);
    addr_reg <= a;
    strb_n_reg <= 1'b0;
    rd_n_reg <= 1'b0;
    repeat (2) @(posedge core_clk);
    d = host_data_out;
    oe = host_data_oe;
    dir = host_dir;
    strb_n_reg <= 1'b1;
    rd_n_reg <= 1'b1;
    repeat (2) @(posedge core_clk);
  endtask : rd
endmodule : mbx_host_model

// ---- tb/mbx_mailbox_tb.sv ----
// Self-checking bench for the host mailbox
`timescale 1ns/1ns

module mbx_mailbox_tb;
  localparam logic [3:0] UID = 4'h5; // Arbitrary value
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  mbx_pkg::mbx_host_bus_type host_bus;
  logic [7:0] host_data_out;
  logic host_data_oe;
  logic host_dir;
  logic host_ready;
  logic wait_expired;
  logic [7:0] lport = 8'h00;
  logic liorq_n = 1'b1;
  logic lrd_n = 1'b1;
  logic lwr_n = 1'b1;
  logic lack_n = 1'b1;
  logic [7:0] ldin = 8'h00;
  logic [7:0] local_data_out;
  logic local_data_oe;
  logic local_irq_n;
  logic [7:0] got;
  logic goe;
  logic gdir;
  int mismatches = 0;
  int n_compared = 0;
  int cyc = 0;

  always #5 core_clk = ~core_clk;

  mbx_mailbox #(.UNIT_ID(UID), .BUF_DEPTH(2)) dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .host_bus(host_bus),
    .host_data_out(host_data_out), .host_data_oe(host_data_oe),
    .host_dir(host_dir), .host_ready(host_ready), .local_port(lport),
    .local_io_request_strobe_n(liorq_n), .local_rd_n(lrd_n), .local_wr_n(lwr_n),
    .vector_acknowledge_n(lack_n), .local_data_in(ldin),
    .local_data_out(local_data_out), .local_data_oe(local_data_oe),
    .local_irq_n(local_irq_n));

  mbx_host_model host (
    .core_clk(core_clk), .host_bus(host_bus),
    .host_data_out(host_data_out), .host_data_oe(host_data_oe),
    .host_dir(host_dir), .host_ready(host_ready),
    .wait_expired(wait_expired));

  task automatic end_sim;
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim

  task automatic chk8(input string what, input logic [7:0] exp,
                      input logic [7:0] act);
    n_compared++;
    if (act !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, act);
    end
  endtask : chk8

  task automatic chk1(input string what, input logic exp, input logic act);
    n_compared++;
    if (act !== exp) begin
      mismatches++;
      $display("BAD %s expected %b seen %b", what, exp, act);
    end
  endtask : chk1

  task automatic lrd(input logic [7:0] p, output logic [7:0] d);
    @(posedge core_clk);
    lport <= p;
    liorq_n <= 1'b0;
    lrd_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    d = local_data_out;
    liorq_n <= 1'b1;
    lrd_n <= 1'b1;
    repeat (3) @(posedge core_clk);
  endtask : lrd

  task automatic lwr(input logic [7:0] p, input logic [7:0] d);
    @(posedge core_clk);
    lport <= p;
    ldin <= d;
    liorq_n <= 1'b0;
    lwr_n <= 1'b0;
    @(posedge core_clk);
    liorq_n <= 1'b1;
    lwr_n <= 1'b1;
    repeat (2) @(posedge core_clk);
  endtask : lwr

  // Acknowledge and return the vector the unit offered
  task automatic ack(output logic [7:0] d);
    @(posedge core_clk);
    lack_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    d = local_data_out;
    lack_n <= 1'b1;
    repeat (3) @(posedge core_clk);
  endtask : ack

  task automatic status(input logic [3:0] low);
    host.rd(8'h81, got, goe, gdir);
    chk8("status", {UID, low}, got);
    chk1("status oe", 1'b1, goe);
    chk1("status dir", 1'b1, gdir);
  endtask : status

  task automatic sc_decode;
    logic [7:0] miss [5] = '{8'h00, 8'h01, 8'h82, 8'hC1, 8'h7F};
    foreach (miss[i]) host.wr(miss[i], 8'hFF);
    chk1("irq after foreign writes", 1'b1, local_irq_n);
    host.rd(8'h83, got, goe, gdir);
    chk1("oe on foreign read", 1'b0, goe);
    status(4'h0);
  endtask : sc_decode

  task automatic sc_fetch;
    lwr(8'h00, 8'h5A);
    status(4'h1);
    host.rd(8'h80, got, goe, gdir);
    chk8("fetched byte", 8'h5A, got);
    chk1("host oe released", 1'b0, host_data_oe);
    chk1("irq on fetch", 1'b0, local_irq_n);
    status(4'h4);
    ack(got);
    chk8("fetch vector", 8'h02, got);
    chk1("irq after ack", 1'b1, local_irq_n);
    chk1("local oe released", 1'b0, local_data_oe);
  endtask : sc_fetch

  task automatic sc_store_cmd;
    host.wr(8'h80, 8'h3C);
    host.wr(8'h81, 8'hA5);
    status(4'hA);
    ack(got);
    chk8("cmd vector first", 8'h04, got);
    chk1("store still pending", 1'b0, local_irq_n);
    ack(got);
    chk8("store vector", 8'h08, got);
    chk1("irq after both acks", 1'b1, local_irq_n);
    lrd(8'h03, got);
    chk8("stored byte", 8'h3C, got);
    lrd(8'h03, got);
    chk8("command byte", 8'hA5, got);
    status(4'h0);
  endtask : sc_store_cmd

  // Fill input register and buffer, reset the flags, then drain in order
  task automatic sc_fill;
    logic [7:0] vals [3] = '{8'h11, 8'h22, 8'h33};
    host.wr(8'h80, 8'h99);
    lrd(8'h03, got);
    chk8("single byte", 8'h99, got);
    chk1("irq after port read", 1'b1, local_irq_n);
    foreach (vals[i]) host.wr(8'h80, vals[i]);
    chk1("buffer full", 1'b0, host_ready);
    lwr(8'h01, 8'h00);
    chk1("irq after program reset", 1'b1, local_irq_n);
    foreach (vals[i]) begin
      lrd(8'h03, got);
      chk8("drained byte", vals[i], got);
    end
    chk1("buffer ready again", 1'b1, host_ready);
    host.wr(8'h81, 8'h42);
    sys_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk1("irq after host reset", 1'b1, local_irq_n);
  endtask : sc_fill

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      end_sim();
    end
  end

  initial begin
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    chk1("irq at reset", 1'b1, local_irq_n);
    chk1("host oe at reset", 1'b0, host_data_oe);
    repeat (2) @(posedge core_clk);
    chk1("ready after reset", 1'b1, host_ready);
    sc_decode();
    sc_fetch();
    sc_store_cmd();
    sc_fill();
    chk1("host wait expired", 1'b0, wait_expired);
    end_sim();
  end
endmodule : mbx_mailbox_tb
